// >>> rtl/hcom_pkg.sv
// Shared constants and carriers for the homing setup and output mode block.
// Assumes a 32-bit Avalon-MM register slave with byte addresses.
package hcom_pkg;
   // Register byte offsets
   localparam logic [4:0] ADDR_MODE = 5'h00;
   localparam logic [4:0] ADDR_SETUP = 5'h04;
   localparam logic [4:0] ADDR_CMD = 5'h08;
   localparam logic [4:0] ADDR_STATUS = 5'h0C;
   localparam logic [4:0] ADDR_REPORT = 5'h10;
   // Output function select
   localparam logic [2:0] MODE_MIN = 3'h1;
   localparam logic [2:0] MODE_MAX = 3'h6;
   localparam logic [2:0] MODE_RESET = 3'h1;
   localparam logic [2:0] MODE_SLIP_A = 3'h2;
   localparam logic [2:0] MODE_MOVE_PROG = 3'h3;
   localparam logic [2:0] MODE_SLIP_B = 3'h4;
   localparam logic [2:0] MODE_REG_OK = 3'h5;
   localparam logic [2:0] MODE_REG_FAIL = 3'h6;
   // Setup bit positions, A at bit 0 through H at bit 7
   localparam int SB_RESOLVER = 0;
   localparam int SB_BACKUP = 1;
   localparam int SB_POLARITY = 2;
   localparam int SB_JOG = 4;
   localparam int SB_FINAL_DIR = 6;
   localparam int SB_EDGE = 7;
   localparam logic [7:0] SETUP_MASK = 8'hD7; // D and F undefined
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [7:0] REPORT_LEAD = 8'h2A; // Asterisk character
   // Command field layout
   localparam int CMD_OUT1_LSB = 4;
   localparam int CMD_OUT2_LSB = 6;
   localparam logic [2:0] OP_OUT_BUF = 3'h1;
   localparam logic [2:0] OP_OUT_IMM = 3'h2;
   localparam logic [2:0] OP_AMP_ON = 3'h3;
   localparam logic [2:0] OP_AMP_OFF = 3'h4;
   localparam logic [2:0] OP_SHUT_BUF = 3'h5;
   localparam logic [2:0] OP_SHUTCLR_BUF = 3'h6;
   localparam logic [2:0] OP_HOME_BUF = 3'h7;
   localparam logic AMP_RESET = 1'b1;

   typedef struct packed {
      logic [2:0] op;
      logic [1:0] out1_code;
      logic [1:0] out2_code;
   } hcom_cmd_s;

   typedef struct packed {
      logic resolver_en;
      logic backup_en;
      logic polarity;
      logic final_ccw;
   } hcom_home_cfg_s;
endpackage

// >>> rtl/hcom_outmux.sv
// Output function selection for the two digital outputs.
// Assumes all sources are synchronous to mclk_i.
`timescale 1ns/1ns
module hcom_outmux
   import hcom_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [2:0] mode_i,
   input wire logic prog1_i,
   input wire logic prog2_i,
   input wire logic moving_i,
   input wire logic slip_i,
   input wire logic reg_seen_i,
   input wire logic reg_fail_i,
   output logic out1_o,
   output logic out2_o
);
   logic next_out1;
   logic next_out2;

   // Route each output by mode; servo-only correction never reaches moving_i
   always_comb begin
      next_out1 = moving_i;
      next_out2 = prog2_i;
      unique case (mode_i)
         MODE_RESET: begin
            next_out1 = prog1_i;
            next_out2 = prog2_i;
         end
         MODE_SLIP_A: begin
            next_out1 = prog1_i;
            next_out2 = slip_i;
         end
         MODE_MOVE_PROG: next_out2 = prog2_i;
         MODE_SLIP_B: next_out2 = slip_i;
         MODE_REG_OK: next_out2 = reg_seen_i;
         MODE_REG_FAIL: next_out2 = reg_fail_i;
         default: begin
            next_out1 = 1'b0;
            next_out2 = 1'b0;
         end
      endcase
   end

   // Outputs from flops, one cycle behind the sources
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         out1_o <= 1'b0;
         out2_o <= 1'b0;
      end else begin
         out1_o <= next_out1;
         out2_o <= next_out2;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   property p_prog_only;
      (mode_i == MODE_RESET) |=> (out1_o == $past(prog1_i)) && (out2_o == $past(prog2_i));
   endproperty
   a_prog_only: assert property (p_prog_only) else $error("Programmable mode mismatch");

   property p_moving;
      (mode_i >= MODE_MOVE_PROG) && (mode_i <= MODE_MAX) |=> out1_o == $past(moving_i);
   endproperty
   a_moving: assert property (p_moving) else $error("Moving output mismatch");

   property p_slip_out;
      (mode_i == MODE_SLIP_A || mode_i == MODE_SLIP_B) && slip_i |=> out2_o;
   endproperty
   a_slip_out: assert property (p_slip_out) else $error("Slip output not shown");
endmodule

// >>> rtl/hcom_homing.sv
// Homing sequencer: seek, optional back-up, optional resolver creep.
// Assumes the motion core reports stop and resolver arrival as levels.
`timescale 1ns/1ns
module hcom_homing
   import hcom_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire hcom_home_cfg_s cfg_i,
   input wire logic home_closed_i,
   input wire logic stopped_i,
   input wire logic resolver_at_target_i,
   output logic seek_o,
   output logic decel_o,
   output logic reverse_o,
   output logic dir_ccw_o,
   output logic creep_o,
   output logic declared_o
);
   typedef enum logic [2:0] {HM_IDLE, HM_SEEK, HM_DECEL, HM_REVERSE, HM_CREEP} hcom_hstate_e;
   hcom_hstate_e state;
   hcom_hstate_e next_state;
   logic home_act;
   logic home_prev;
   logic next_declared;
   logic edge_hit;

   // Polarity 0 takes a closed switch as active
   assign home_act = cfg_i.polarity ? ~home_closed_i : home_closed_i;
   assign edge_hit = home_act & ~home_prev;

   // Next state; abort wins over everything
   always_comb begin
      next_state = state;
      next_declared = 1'b0;
      unique case (state)
         HM_IDLE: if (start_i) next_state = HM_SEEK;
         HM_SEEK: begin
            if (edge_hit && cfg_i.backup_en) begin
               next_state = HM_DECEL;
            end else if (edge_hit && cfg_i.resolver_en) begin
               next_state = HM_CREEP;
            end else if (edge_hit) begin
               next_state = HM_IDLE;
               next_declared = 1'b1;
            end
         end
         HM_DECEL: if (stopped_i) next_state = HM_REVERSE;
         HM_REVERSE: begin
            if (edge_hit && cfg_i.resolver_en) begin
               next_state = HM_CREEP;
            end else if (edge_hit) begin
               next_state = HM_IDLE;
               next_declared = 1'b1;
            end
         end
         HM_CREEP: begin
            if (resolver_at_target_i) begin
               next_state = HM_IDLE;
               next_declared = 1'b1;
            end
         end
      endcase
      if (abort_i) begin
         next_state = HM_IDLE;
         next_declared = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= HM_IDLE;
         home_prev <= 1'b1; // Avoid a false edge right after reset
         declared_o <= 1'b0;
      end else begin
         state <= next_state;
         home_prev <= home_act;
         declared_o <= next_declared;
      end
   end

   assign seek_o = (state == HM_SEEK);
   assign decel_o = (state == HM_DECEL);
   assign reverse_o = (state == HM_REVERSE);
   assign creep_o = (state == HM_CREEP);
   // Final direction only matters during the back-up approach
   assign dir_ccw_o = reverse_o & cfg_i.final_ccw;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_seek_edge;
      seek_o && edge_hit && !abort_i;
   endsequence

   property p_no_backup;
      s_seek_edge and !cfg_i.backup_en && !cfg_i.resolver_en |=> declared_o && !seek_o;
   endproperty
   a_no_backup: assert property (p_no_backup) else $error("Home not declared at edge");

   property p_backup;
      s_seek_edge and cfg_i.backup_en |=> decel_o;
   endproperty
   a_backup: assert property (p_backup) else $error("Back-up not started");

   property p_resolver;
      (s_seek_edge and cfg_i.resolver_en && !cfg_i.backup_en) |=> creep_o && !declared_o;
   endproperty
   a_resolver: assert property (p_resolver) else $error("Resolver creep skipped");

   property p_dir;
      !reverse_o |-> !dir_ccw_o;
   endproperty
   a_dir: assert property (p_dir) else $error("Direction driven outside back-up");
endmodule

// >>> rtl/hcom_top.sv
// Output mode, amplifier command and homing setup block with an Avalon-MM slave.
// Assumes a single 50 MHz clock and motion-core status synchronous to it.
// Functional notes
// - Servo-only corrections never raise moving output
// - Slip output: set on deadband, clear on fault
// - Registration-occurred holds until next move starts
// - Registration-failed when previous move saw none
// - Mode one: both outputs only programmable
// - Output code X keeps, 1 sets, 0 clears
// - Amplifier on restores torque, stops motion
// - Amplifier on immediate; shutdown clear buffered
// - Report: asterisk then setup bits A..H
// - Resolver homing creeps to target after home
// - Without resolver, homing by backup/direction only
// - No backup, no resolver: declare home at edge
// - Backup: stop, reverse at final velocity, declare
// - Polarity bit selects closed or open active
// - Jog bit lets trigger inputs jog
// - Final direction: 0 clockwise, 1 counter-clockwise
// - Final direction matters only with backup set
// - Mode field 1..6, default 1, assigns outputs
// - Moving output follows indexer move command
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module hcom_top
   import hcom_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic indexer_cmd_move_i,
   input wire logic move_start_i,
   input wire logic move_end_i,
   input wire logic motion_stopped_i,
   input wire logic deadband_exceeded_i,
   input wire logic slip_fault_i,
   input wire logic reg_enable_i,
   input wire logic reg_detect_i,
   input wire logic home_closed_i,
   input wire logic resolver_at_target_i,
   input wire logic [1:0] trigger_i,
   output logic out1_o,
   output logic out2_o,
   output logic amp_enable_o,
   output logic stop_motion_o,
   output logic [1:0] jog_o,
   output logic home_seek_o,
   output logic home_decel_o,
   output logic home_reverse_o,
   output logic home_dir_ccw_o,
   output logic home_creep_o,
   output logic home_declared_o
);
   logic ack;
   logic [31:0] rdata;
   logic [2:0] output_function_select;
   logic [7:0] setup;
   logic pend_valid;
   hcom_cmd_s pend_cmd;
   logic prog1;
   logic prog2;
   logic amp_on;
   logic stop_pulse;
   logic home_go;
   logic next_ack;
   logic [31:0] next_rdata;
   logic [2:0] next_mode;
   logic [7:0] next_setup;
   logic next_pend_valid;
   hcom_cmd_s next_pend_cmd;
   logic next_prog1;
   logic next_prog2;
   logic next_amp_on;
   logic next_stop_pulse;
   logic next_home_go;
   logic reg_seen;
   logic reg_fail;
   logic slip_flag;
   logic next_reg_seen;
   logic next_reg_fail;
   logic next_slip_flag;
   logic req;
   logic stall;
   logic wr_take;
   hcom_cmd_s wcmd;
   hcom_home_cfg_s home_cfg;
   logic [7:0] report_bits;

   // Output-set code: 1x keeps, 01 sets, 00 clears
   function automatic logic apply_code(input logic [1:0] code, input logic cur);
      apply_code = code[1] ? cur : code[0];
   endfunction

   function automatic logic is_buffered(input logic [2:0] op);
      is_buffered = (op == OP_OUT_BUF) || (op == OP_SHUT_BUF) || (op == OP_SHUTCLR_BUF)
         || (op == OP_HOME_BUF);
   endfunction

   assign wcmd.op = avs_writedata_i[2:0];
   assign wcmd.out1_code = avs_writedata_i[CMD_OUT1_LSB +: 2];
   assign wcmd.out2_code = avs_writedata_i[CMD_OUT2_LSB +: 2];
   assign req = avs_read_i | avs_write_i;
   // A buffered command waits while the one-deep buffer is occupied
   assign stall = avs_write_i && (avs_address_i == ADDR_CMD) && pend_valid
      && is_buffered(wcmd.op);
   assign avs_waitrequest_o = req & ~ack;
   assign wr_take = avs_write_i & ack;
   assign avs_readdata_o = rdata;
   assign report_bits = setup & SETUP_MASK;

   // Bus, configuration and command handling
   always_comb begin
      next_ack = req & ~ack & ~stall;
      next_rdata = rdata;
      next_mode = output_function_select;
      next_setup = setup;
      next_pend_valid = pend_valid;
      next_pend_cmd = pend_cmd;
      next_prog1 = prog1;
      next_prog2 = prog2;
      next_amp_on = amp_on;
      next_stop_pulse = 1'b0;
      next_home_go = 1'b0;
      // Buffered work runs in order, only once the indexer holds position
      if (pend_valid && !indexer_cmd_move_i) begin
         next_pend_valid = 1'b0;
         unique case (pend_cmd.op)
            OP_OUT_BUF: begin
               next_prog1 = apply_code(pend_cmd.out1_code, prog1);
               next_prog2 = apply_code(pend_cmd.out2_code, prog2);
            end
            OP_SHUT_BUF: next_amp_on = 1'b0;
            OP_SHUTCLR_BUF: next_amp_on = 1'b1;
            OP_HOME_BUF: next_home_go = 1'b1;
            default: next_pend_valid = 1'b0;
         endcase
      end
      // Read data is captured in the cycle the request is first seen
      if (avs_read_i && !ack) begin
         unique case (avs_address_i)
            ADDR_MODE: next_rdata = {29'h0000000, output_function_select};
            ADDR_SETUP: next_rdata = {24'h000000, report_bits};
            ADDR_STATUS: next_rdata = {20'h00000, home_declared_o, home_creep_o,
               home_reverse_o, home_seek_o, pend_valid, amp_on, slip_flag, reg_fail,
               reg_seen, indexer_cmd_move_i, out2_o, out1_o};
            ADDR_REPORT: next_rdata = {16'h0000, REPORT_LEAD, report_bits};
            default: next_rdata = 32'h00000000;
         endcase
      end
      if (wr_take) begin
         unique case (avs_address_i)
            ADDR_MODE: begin
               // Out-of-range modes are ignored
               if (avs_writedata_i[2:0] >= MODE_MIN && avs_writedata_i[2:0] <= MODE_MAX) begin
                  next_mode = avs_writedata_i[2:0];
               end
            end
            ADDR_SETUP: next_setup = avs_writedata_i[7:0] & SETUP_MASK;
            ADDR_CMD: begin
               unique case (wcmd.op)
                  OP_OUT_IMM: begin
                     next_prog1 = apply_code(wcmd.out1_code, next_prog1);
                     next_prog2 = apply_code(wcmd.out2_code, next_prog2);
                  end
                  OP_AMP_ON: begin
                     next_amp_on = 1'b1;
                     next_stop_pulse = 1'b1;
                  end
                  OP_AMP_OFF: begin
                     // Turning off also discards queued work
                     next_amp_on = 1'b0;
                     next_pend_valid = 1'b0;
                  end
                  OP_OUT_BUF, OP_SHUT_BUF, OP_SHUTCLR_BUF, OP_HOME_BUF: begin
                     next_pend_valid = 1'b1;
                     next_pend_cmd = wcmd;
                  end
                  default: next_pend_valid = next_pend_valid;
               endcase
            end
            default: next_ack = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ack <= 1'b0;
         rdata <= 32'h00000000;
         output_function_select <= MODE_RESET;
         setup <= SETUP_RESET;
         pend_valid <= 1'b0;
         pend_cmd <= '0;
         prog1 <= 1'b0;
         prog2 <= 1'b0;
         amp_on <= AMP_RESET;
         stop_pulse <= 1'b0;
         home_go <= 1'b0;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
         output_function_select <= next_mode;
         setup <= next_setup;
         pend_valid <= next_pend_valid;
         pend_cmd <= next_pend_cmd;
         prog1 <= next_prog1;
         prog2 <= next_prog2;
         amp_on <= next_amp_on;
         stop_pulse <= next_stop_pulse;
         home_go <= next_home_go;
      end
   end

   // Registration and slip tracking; a set in the clearing cycle wins
   always_comb begin
      next_reg_seen = reg_seen;
      next_reg_fail = reg_fail;
      next_slip_flag = slip_flag;
      if (move_start_i) begin
         next_reg_seen = 1'b0;
         next_reg_fail = 1'b0;
      end
      if (reg_enable_i && reg_detect_i) next_reg_seen = 1'b1;
      if (move_end_i && !reg_seen) next_reg_fail = 1'b1;
      if (slip_fault_i) next_slip_flag = 1'b0;
      if (deadband_exceeded_i) next_slip_flag = 1'b1;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         reg_seen <= 1'b0;
         reg_fail <= 1'b0;
         slip_flag <= 1'b0;
      end else begin
         reg_seen <= next_reg_seen;
         reg_fail <= next_reg_fail;
         slip_flag <= next_slip_flag;
      end
   end

   assign amp_enable_o = amp_on;
   assign stop_motion_o = stop_pulse;
   // Jogging only when enabled; input selection lives with the input mode logic
   assign jog_o = setup[SB_JOG] ? trigger_i : 2'b00;
   assign home_cfg.resolver_en = setup[SB_RESOLVER];
   assign home_cfg.backup_en = setup[SB_BACKUP];
   assign home_cfg.polarity = setup[SB_POLARITY];
   assign home_cfg.final_ccw = setup[SB_FINAL_DIR];

   hcom_outmux u_outmux (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .mode_i(output_function_select),
      .prog1_i(prog1),
      .prog2_i(prog2),
      .moving_i(indexer_cmd_move_i),
      .slip_i(slip_flag),
      .reg_seen_i(reg_seen),
      .reg_fail_i(reg_fail),
      .out1_o(out1_o),
      .out2_o(out2_o)
   );

   hcom_homing u_homing (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(home_go),
      .abort_i(stop_pulse | ~amp_on),
      .cfg_i(home_cfg),
      .home_closed_i(home_closed_i),
      .stopped_i(motion_stopped_i),
      .resolver_at_target_i(resolver_at_target_i),
      .seek_o(home_seek_o),
      .decel_o(home_decel_o),
      .reverse_o(home_reverse_o),
      .dir_ccw_o(home_dir_ccw_o),
      .creep_o(home_creep_o),
      .declared_o(home_declared_o)
   );

   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_amp_on_cmd;
      wr_take && avs_address_i == ADDR_CMD && wcmd.op == OP_AMP_ON;
   endsequence

   property p_amp_on;
      s_amp_on_cmd |=> amp_enable_o && stop_motion_o ##1 !stop_motion_o;
   endproperty
   a_amp_on: assert property (p_amp_on) else $error("Amplifier on not immediate");

   property p_buf_wait;
      pend_valid && indexer_cmd_move_i && !(wr_take && avs_address_i == ADDR_CMD
         && (wcmd.op == OP_AMP_OFF || wcmd.op == OP_AMP_ON))
         |=> pend_valid && $stable(amp_on);
   endproperty
   a_buf_wait: assert property (p_buf_wait) else $error("Buffered command ran early");

   property p_reg_hold;
      reg_seen && !move_start_i |=> reg_seen;
   endproperty
   a_reg_hold: assert property (p_reg_hold) else $error("Registration flag dropped");

   property p_reg_clear;
      move_start_i && !(reg_enable_i && reg_detect_i) |=> !reg_seen && !reg_fail;
   endproperty
   a_reg_clear: assert property (p_reg_clear) else $error("Registration not cleared");

   property p_reg_fail;
      move_end_i && !reg_seen && !move_start_i |=> reg_fail;
   endproperty
   a_reg_fail: assert property (p_reg_fail) else $error("Registration failure missed");

   property p_slip;
      slip_fault_i && !deadband_exceeded_i |=> !slip_flag;
   endproperty
   a_slip: assert property (p_slip) else $error("Slip fault did not clear output");

   property p_mode_range;
      output_function_select >= MODE_MIN && output_function_select <= MODE_MAX;
   endproperty
   a_mode_range: assert property (p_mode_range) else $error("Mode out of range");

   property p_report;
      avs_read_i && !ack && avs_address_i == ADDR_REPORT
         |=> avs_readdata_o[15:0] == {REPORT_LEAD, $past(setup) & SETUP_MASK};
   endproperty
   a_report: assert property (p_report) else $error("Setup report wrong");
endmodule

// >>> testbench/hcom_motion_model.sv
// Motion core stand-in: runs an eight-cycle indexed move on request.
// Assumes go_i is a one-cycle request made just after a rising edge.
`timescale 1ns/1ns
module hcom_motion_model (
   input wire logic mclk_i,
   input wire logic go_i,
   output logic cmd_move_o,
   output logic start_o,
   output logic end_o,
   output logic stopped_o
);
   int cnt;
   initial begin
      cnt = 0;
      cmd_move_o = 1'b0;
      start_o = 1'b0;
      end_o = 1'b0;
      stopped_o = 1'b1;
   end
   // Only commanded moves reach cmd_move, never servo corrections
   always @(posedge mclk_i) begin
      start_o <= go_i;
      end_o <= (cnt == 1);
      cnt <= go_i ? 8 : (cnt > 0 ? cnt - 1 : 0);
      cmd_move_o <= go_i || cnt > 1;
      stopped_o <= !(go_i || cnt > 0);
   end
endmodule

// >>> testbench/hcom_top_tb.sv
// Self-checking bench for hcom_top: bus, output modes, amplifier, homing.
// Assumes hcom_motion_model supplies move status.
`timescale 1ns/1ns
module hcom_top_tb;
   import hcom_pkg::*;
   logic clk, rst, rd, wr, mv, db, sf, re, rdt, hc, rat, decl, stp;
   logic [4:0] ad;
   logic [31:0] wd, rdata, q;
   logic [1:0] trg, jog;
   logic wait_o, o1, o2, amp, stop, cm, ms, me, mst, seek, rev, dcw, decl_seen;
   int errors, checks;
   hcom_motion_model hcom_motion_model_i (.mclk_i(clk), .go_i(mv), .cmd_move_o(cm),
      .start_o(ms), .end_o(me), .stopped_o(mst));
   hcom_top hcom_top_i (.mclk_i(clk), .sys_rst_i(rst), .avs_address_i(ad), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .indexer_cmd_move_i(cm), .move_start_i(ms),
      .move_end_i(me), .motion_stopped_i(mst), .deadband_exceeded_i(db),
      .slip_fault_i(sf), .reg_enable_i(re), .reg_detect_i(rdt), .home_closed_i(hc),
      .resolver_at_target_i(rat), .trigger_i(trg), .out1_o(o1), .out2_o(o2),
      .amp_enable_o(amp), .stop_motion_o(stop), .jog_o(jog), .home_seek_o(seek),
      .home_decel_o(), .home_reverse_o(rev), .home_dir_ccw_o(dcw), .home_creep_o(),
      .home_declared_o(decl));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Sticky catchers for one-cycle pulses
   always @(posedge clk) begin
      if (stop === 1'b1) stp <= 1'b1;
   end
   always @(posedge clk) begin
      if (decl === 1'b1) decl_seen <= 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon access; waitrequest and read data taken at the same rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      ad <= a;
      wd <= d;
      do begin
         @(posedge clk);
      end while (wait_o !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      tick(2);
   endtask
   // Strobe picks: move request, deadband, slip fault, registration mark
   localparam logic [3:0] P_MV = 4'h8;
   localparam logic [3:0] P_DB = 4'h4;
   localparam logic [3:0] P_SF = 4'h2;
   localparam logic [3:0] P_RDT = 4'h1;
   // One-cycle strobe; no ref argument, so the drive stays non-blocking
   task automatic pulse(input logic [3:0] s);
      {mv, db, sf, rdt} <= s;
      @(posedge clk);
      {mv, db, sf, rdt} <= 4'h0;
   endtask
   task automatic t_reset;
      bus(0, ADDR_MODE, 0); chk(q, 1);
      bus(0, ADDR_SETUP, 0); chk(q, 0);
      bus(0, ADDR_REPORT, 0); chk(q, 32'h2A00);
      bus(1, ADDR_MODE, 32'h7); bus(0, ADDR_MODE, 0); chk(q, 1);
      chk(amp, 1);
   endtask
   task automatic t_setup;
      trg <= 2'h2;
      bus(1, ADDR_SETUP, 32'hFF); bus(0, ADDR_REPORT, 0); chk(q, 32'h2AD7);
      chk(jog, 2'h2);
      bus(1, ADDR_SETUP, 0); chk(jog, 2'h0);
   endtask
   task automatic t_outputs;
      bus(1, ADDR_CMD, 32'h52); chk({o1, o2}, 2'h3);
      bus(1, ADDR_CMD, 32'h22); chk({o1, o2}, 2'h2);
      pulse(P_DB); tick(3); chk(o2, 0);
      bus(1, ADDR_MODE, 2); pulse(P_SF); tick(3); chk(o2, 0);
      pulse(P_DB); tick(3); chk(o2, 1);
      pulse(P_SF); tick(3); chk(o2, 0);
   endtask
   task automatic t_reg;
      re <= 1'b1;
      bus(1, ADDR_MODE, 5); pulse(P_MV); tick(3); chk(o1, 1);
      pulse(P_RDT); tick(2); chk(o2, 1);
      tick(8); chk({o1, o2}, 2'h1);
      pulse(P_MV); tick(3); chk(o2, 0);
      tick(10); bus(1, ADDR_MODE, 6); tick(2); chk(o2, 1);
   endtask
   task automatic t_amp;
      bus(1, ADDR_CMD, 32'h4); chk(amp, 0);
      pulse(P_MV); bus(1, ADDR_CMD, 32'h6); chk(amp, 0);
      tick(10); chk(amp, 1);
      bus(1, ADDR_CMD, 32'h4); pulse(P_MV); stp <= 1'b0;
      bus(1, ADDR_CMD, 32'h3); chk({amp, stp}, 2'h3);
      tick(10);
   endtask
   task automatic t_home;
      hc <= 1'b1; decl_seen <= 1'b0;
      bus(1, ADDR_SETUP, 32'h44); bus(1, ADDR_CMD, 32'h7); tick(2); chk(seek, 1);
      chk(dcw, 0);
      hc <= 1'b0; tick(5); chk(decl_seen, 1);
      // Back-up homing with counter-clockwise final approach
      bus(1, ADDR_SETUP, 32'h42); bus(1, ADDR_CMD, 32'h7); tick(2); chk(seek, 1);
      hc <= 1'b1; tick(3); chk({rev, dcw}, 2'h3);
      hc <= 1'b0; decl_seen <= 1'b0; tick(2);
      hc <= 1'b1; tick(3); chk({decl_seen, rev}, 2'h2);
   endtask
   task automatic close_out;
      $display("mismatches %0d, comparisons %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      {rd, wr, mv, db, sf, re, rdt, hc, rat, stp, decl_seen} = '0;
      ad = '0; wd = '0; trg = '0; errors = 0; checks = 0; rst = 1'b1;
      tick(16);
      rst <= 1'b0;
      t_reset; t_setup; t_outputs; t_reg; t_amp; t_home;
      close_out;
   end
   initial begin
      #400000;
      errors++;
      close_out;
   end
endmodule
